// *** bench/wwd_bench.sv ***
// bench: model host, event timing model and checks
`timescale 1ns/1ps
module wwd_bench;
	import wwd_pkg::*;
	localparam int T = 4;
	logic             core_clk_in = 1'b0;
	logic             rst_in = 1'b1;
	logic             ack_in;
	logic             mr_pin_in = 1'b0;
	logic [OHM_W-1:0] interval_resistor_in = 16'h0000;
	logic             sense_en_out, alert_out, host_reset_n_out, host_reset_n_oe_out, en = 1'b1;
	int               dly = 40, seed = 78704, err_count = 0, samples_checked = 0;
	int               now = 0, iv, t0, t_on, t_off, t_read;
	int               rise_q[$];
	wire              line_n = host_reset_n_oe_out ? host_reset_n_out : 1'b1;
	wwd_top #(.TICK_CYC(T)) i_wwd_top (.core_clk_in(core_clk_in), .rst_in(rst_in), .ack_in(ack_in),
		.mr_pin_in(mr_pin_in), .interval_resistor_in(interval_resistor_in), .sense_en_out(sense_en_out),
		.alert_out(alert_out), .host_reset_n_out(host_reset_n_out), .host_reset_n_oe_out(host_reset_n_oe_out));
	wwd_host i_wwd_host (.clk_in(core_clk_in), .alert_in(alert_out), .line_n_in(line_n), .en_in(en),
		.dly_in(dly), .ack_out(ack_in));
	initial forever #2 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		now++;
		if ($rose(alert_out)) rise_q.push_back(now);
		if ($rose(host_reset_n_oe_out)) t_on = now;
		if ($fell(host_reset_n_oe_out)) t_off = now;
		if ($fell(sense_en_out)) t_read = now;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(string name, logic signed [31:0] exp, logic signed [31:0] got, int tol);
		samples_checked++;
		if ($isunknown(got) || got < exp - tol || got > exp + tol) begin
			err_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task automatic wait_oe(input logic v);
		int i;
		for (i = 0; i < 20000 && host_reset_n_oe_out !== v; i++) @(negedge core_clk_in);
		// one more edge so the recorder has stamped the change
		@(negedge core_clk_in);
		if (i == 20000) begin
			err_count++;
			finish_test();
		end
	endtask
	initial begin
		interval_resistor_in = 16'(500 * (1 + $unsigned($random(seed)) % 9));
		iv = (interval_resistor_in / STEP_OHM) * STEP_MS * T;
		repeat (2) @(negedge core_clk_in);
		rst_in = 1'b0;
		repeat (50 * T) @(negedge core_clk_in);
		mr_pin_in = 1'b1;
		repeat (10 * T) @(negedge core_clk_in);
		mr_pin_in = 1'b0;
		t0 = now;
		dly = 10 + $unsigned($random(seed)) % 60;
		wait_oe(1'b0);
		chk("read end", t0 + READ_MS * T, t_read, 2 * T);
		interval_resistor_in = 16'h2328;
		repeat (3 * iv + 8) @(negedge core_clk_in);
		chk("first wake", t_off + iv, rise_q[0], 1);
		chk("wake spacing", iv, rise_q[2] - rise_q[1], 0);
		en = 1'b0;
		wait_oe(1'b1);
		chk("miss to reset", rise_q[$] + iv, t_on, 1);
		t0 = t_on;
		en = 1'b1;
		dly = iv - 10 * T;
		wait_oe(1'b0);
		wait_oe(1'b1);
		chk("reset spacing", t0 + iv + RST_PULSE_MS * T, t_on, 1);
		dly = 40;
		wait_oe(1'b0);
		repeat (iv / 2) @(negedge core_clk_in);
		mr_pin_in = 1'b1;
		repeat (15 * T) @(negedge core_clk_in);
		mr_pin_in = 1'b0;
		repeat (30 * T) @(negedge core_clk_in);
		chk("glitch", 0, host_reset_n_oe_out, 0);
		// validation lands about 5 ms into a wake pulse that the host acks late
		t0 = t_off + ((now - t_off + 61) / iv + 1) * iv - 61;
		repeat (t0 - now) @(negedge core_clk_in);
		dly = 70;
		mr_pin_in = 1'b1;
		repeat (25 * T) @(negedge core_clk_in);
		chk("alert on press", 0, alert_out, 0);
		chk("pulse before press", t0 + 61, rise_q[$], 0);
		repeat (15 * T) @(negedge core_clk_in);
		mr_pin_in = 1'b0;
		t0 = now;
		wait_oe(1'b0);
		chk("press hold", t0 + (DEBOUNCE_MS + RST_PULSE_MS) * T, t_off, 5 * T);
		chk("press start", t0 + (MR_VALID_MS - 40) * T, t_on, 3 * T);
		chk("reset data", 0, host_reset_n_out, 0);
		finish_test();
	end
endmodule
bind wwd_top wwd_chk #(.TICK_CYC(TICK_CYC)) i_wwd_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
	.ack_in(ack_in), .mr_pin_in(mr_pin_in), .interval_resistor_in(interval_resistor_in),
	.sense_en_out(sense_en_out), .alert_out(alert_out), .host_reset_n_out(host_reset_n_out),
	.host_reset_n_oe_out(host_reset_n_oe_out));

// *** bench/wwd_chk.sv ***
// checker: port timing assertions for the wake watchdog
`timescale 1ns/1ps
module wwd_chk
	import wwd_pkg::*;
#(
	parameter int TICK_CYC = CYC_PER_MS
) (
	input wire logic             core_clk_in,
	input wire logic             rst_in,
	input wire logic             ack_in,
	input wire logic             mr_pin_in,
	input wire logic [OHM_W-1:0] interval_resistor_in,
	input wire logic             sense_en_out,
	input wire logic             alert_out,
	input wire logic             host_reset_n_out,
	input wire logic             host_reset_n_oe_out
);
	int mr_cnt_q;
	int mr_cnt_d;
	always_comb begin
		mr_cnt_d = mr_pin_in ? mr_cnt_q + 1 : 0;
	end
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mr_cnt_q <= 0;
		end else begin
			mr_cnt_q <= mr_cnt_d;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// ack edge while the wake pulse is still up
	sequence ack_in_alert;
		alert_out && $rose(ack_in);
	endsequence
	AST_RST_DATA: assert property (host_reset_n_out == 1'b0) else $error("reset data high");
	AST_READ_RST: assert property (sense_en_out |-> host_reset_n_oe_out) else $error("released in read");
	AST_READ_ONCE: assert property (!sense_en_out |=> !sense_en_out) else $error("read restarted");
	AST_ALERT_QUIET: assert property (host_reset_n_oe_out |-> !alert_out) else $error("alert in reset");
	AST_ALERT_END: assert property ($rose(alert_out) |-> ##84 !alert_out) else $error("alert too long");
	AST_ACK_DROP: assert property (ack_in_alert |-> ##[1:5] !alert_out) else $error("alert kept");
	AST_RST_HOLD: assert property ($rose(host_reset_n_oe_out) |-> host_reset_n_oe_out[*8]) else $error("short");
	AST_MR_VALID: assert property (mr_cnt_q == 28 * TICK_CYC |-> host_reset_n_oe_out) else $error("press lost");
endmodule

// *** bench/wwd_host.sv ***
// partner model: sleeping host that acknowledges wake pulses
`timescale 1ns/1ps
module wwd_host (
	input  wire logic               clk_in,
	input  wire logic               alert_in,
	input  wire logic               line_n_in,
	input  wire logic               en_in,
	input  wire logic signed [31:0] dly_in,
	output logic                    ack_out
);
	int   cnt = -20;
	logic alert_q = 1'b0;
	logic line_q = 1'b0;
	logic ack_q = 1'b0;
	assign ack_out = ack_q;
	always @(negedge clk_in) begin
		alert_q <= alert_in;
		line_q <= line_n_in;
		// wakes on a pulse or on reset release, then acks after a delay
		if ((alert_in && !alert_q) || (line_n_in && !line_q)) begin
			cnt <= en_in ? dly_in : -20;
		end else if (cnt > -20) begin
			cnt <= cnt - 1;
		end
		ack_q <= cnt <= 0 && cnt > -8;
	end
endmodule

// *** common/wwd_pkg.sv ***
// package: timing constants, state and carrier types for the wake watchdog
package wwd_pkg;
	localparam int CLK_FREQ_HZ    = 250_000_000;
	localparam int CYC_PER_MS     = CLK_FREQ_HZ / 1000;
	localparam int TICK_W         = 18;
	localparam int MS_W           = 10;
	localparam int OHM_W          = 16;
	localparam int ALERT_MS       = 20;  // alert pulse width
	localparam int RST_PULSE_MS   = 320; // reset_pulse_width
	localparam int READ_MS        = 100; // resistor_read_time
	localparam int DEBOUNCE_MS    = 20;  // debounce_time
	localparam int MR_VALID_MS    = 20;  // manual reset must stay high this long
	localparam int MR_WINDOW_MS   = 30;  // observation window
	localparam int ACK_BLANK_MS   = 20;  // ack ignored in the last part of an interval
	localparam int STEP_MS        = 100;
	localparam int STEP_OHM       = 500;
	localparam int STEP_MIN       = 1;
	localparam int STEP_MAX       = 9;
	localparam logic [MS_W-1:0] MS_ZERO = 10'h000;

	typedef enum logic [1:0] {
		ST_READ  = 2'b00,
		ST_RUN   = 2'b01,
		ST_RESET = 2'b10
	} wwd_state_e;

	typedef struct packed {
		wwd_state_e       state;
		logic [MS_W-1:0]  interval_ms;
		logic [MS_W-1:0]  phase_ms;
		logic [MS_W-1:0]  alert_ms;
		logic [MS_W-1:0]  hold_ms;
		logic [MS_W-1:0]  mr_win_ms;
		logic [MS_W-1:0]  mr_high_ms;
		logic             ack_seen;
		logic             alert;
		logic             rst_drive;
	} wwd_ctl_s;
endpackage

// *** rtl/wwd_top.sv ***
// wake watchdog with manual reset: alert pulses, ack supervision, open-drain host reset
`timescale 1ns/1ps
module wwd_top
	import wwd_pkg::*;
#(
	parameter int TICK_CYC = CYC_PER_MS
) (
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	input  wire logic             ack_in,
	input  wire logic             mr_pin_in,
	input  wire logic [OHM_W-1:0] interval_resistor_in,
	output logic                  sense_en_out,
	output logic                  alert_out,
	output logic                  host_reset_n_out,
	output logic                  host_reset_n_oe_out
);
	// ohms to interval in ms, clamped to the sub-second steps
	function automatic logic [MS_W-1:0] ohm_to_ms(input logic [OHM_W-1:0] ohm);
		int steps;
		steps = int'(ohm) / STEP_OHM;
		if (steps < STEP_MIN) begin
			steps = STEP_MIN;
		end else if (steps > STEP_MAX) begin
			steps = STEP_MAX;
		end
		return MS_W'(steps * STEP_MS);
	endfunction

	logic [1:0] ack_sync_q;
	logic [1:0] mr_sync_q;
	logic       ack_prev_q;
	// conversion word is settled long before it is taken, two stages only guard metastability
	logic [OHM_W-1:0] ohm_meta_q;
	logic [OHM_W-1:0] ohm_q;
	logic       ack_rise;
	logic       mr_high;

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_sync_q <= 2'h0;
			mr_sync_q  <= 2'h0;
			ack_prev_q <= 1'b0;
			ohm_meta_q <= '0;
			ohm_q      <= '0;
		end else begin
			ack_sync_q <= {ack_sync_q[0], ack_in};
			mr_sync_q  <= {mr_sync_q[0], mr_pin_in};
			ack_prev_q <= ack_sync_q[1];
			ohm_meta_q <= interval_resistor_in;
			ohm_q      <= ohm_meta_q;
		end
	end

	assign ack_rise = ack_sync_q[1] & ~ack_prev_q;
	assign mr_high  = mr_sync_q[1];

	// millisecond time base, restarted together with the other counters
	logic [TICK_W-1:0] tick_q;
	logic [TICK_W-1:0] tick_d;
	logic              ms_tick;
	logic              tick_restart;

	assign ms_tick = (tick_q == TICK_W'(TICK_CYC - 1));

	always_comb begin
		if (tick_restart || ms_tick) begin
			tick_d = '0;
		end else begin
			tick_d = tick_q + TICK_W'(1);
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_d;
		end
	end

	wwd_ctl_s ctl_q;
	wwd_ctl_s ctl_d;
	logic     mr_valid;

	// debounce: pin must be seen high on 20 ms ticks within a 30 ms window
	always_comb begin
		mr_valid = 1'b0;
		if (ctl_q.state != ST_READ && ms_tick && mr_high &&
		    ctl_q.mr_high_ms == MS_W'(MR_VALID_MS - 1)) begin
			mr_valid = 1'b1;
		end
	end

	always_comb begin
		ctl_d        = ctl_q;
		tick_restart = 1'b0;

		// window tracking, idle until the pin is first seen high
		if (ctl_q.state != ST_READ && ms_tick) begin
			if (ctl_q.mr_win_ms == MS_ZERO && !mr_high) begin
				ctl_d.mr_high_ms = MS_ZERO;
			end else if (ctl_q.mr_win_ms == MS_W'(MR_WINDOW_MS - 1)) begin
				ctl_d.mr_win_ms  = MS_ZERO; // glitch too short, discard
				ctl_d.mr_high_ms = MS_ZERO;
			end else begin
				ctl_d.mr_win_ms  = ctl_q.mr_win_ms + MS_W'(1);
				ctl_d.mr_high_ms = ctl_q.mr_high_ms + MS_W'(mr_high);
			end
		end

		if (ctl_q.alert && ms_tick) begin
			if (ctl_q.alert_ms == MS_W'(ALERT_MS - 1)) begin
				ctl_d.alert = 1'b0;
			end else begin
				ctl_d.alert_ms = ctl_q.alert_ms + MS_W'(1);
			end
		end

		case (ctl_q.state)
			ST_READ: begin
				ctl_d.rst_drive = 1'b1;
				if (mr_high) begin
					ctl_d.phase_ms = MS_ZERO;
					tick_restart   = 1'b1;
				end else if (ms_tick) begin
					if (ctl_q.phase_ms == MS_W'(READ_MS - 1)) begin
						ctl_d.interval_ms = ohm_to_ms(ohm_q);
						ctl_d.state       = ST_RUN;
						ctl_d.rst_drive   = 1'b0;
						ctl_d.phase_ms    = MS_ZERO;
						ctl_d.ack_seen    = 1'b0;
					end else begin
						ctl_d.phase_ms = ctl_q.phase_ms + MS_W'(1);
					end
				end
			end
			ST_RUN: begin
				// only the first edge per interval counts, none in the blank tail
				if (ack_rise && !ctl_q.ack_seen &&
				    ctl_q.phase_ms < ctl_q.interval_ms - MS_W'(ACK_BLANK_MS)) begin
					ctl_d.ack_seen = 1'b1;
					ctl_d.alert    = 1'b0;
				end
				if (ms_tick) begin
					if (ctl_q.phase_ms == ctl_q.interval_ms - MS_W'(1)) begin
						ctl_d.phase_ms = MS_ZERO;
						ctl_d.ack_seen = 1'b0;
						if (ctl_q.ack_seen) begin
							ctl_d.alert    = 1'b1;
							ctl_d.alert_ms = MS_ZERO;
						end else begin
							ctl_d.state     = ST_RESET;
							ctl_d.rst_drive = 1'b1;
							ctl_d.hold_ms   = MS_W'(RST_PULSE_MS);
							ctl_d.alert     = 1'b0;
						end
					end else begin
						ctl_d.phase_ms = ctl_q.phase_ms + MS_W'(1);
					end
				end
			end
			ST_RESET: begin
				// held while the pin stays pressed, then counts down
				if (ms_tick && !mr_high) begin
					if (ctl_q.hold_ms == MS_W'(1)) begin
						ctl_d.state     = ST_RUN;
						ctl_d.rst_drive = 1'b0;
						ctl_d.phase_ms  = MS_ZERO;
						ctl_d.ack_seen  = 1'b0;
					end else begin
						ctl_d.hold_ms = ctl_q.hold_ms - MS_W'(1);
					end
				end
			end
			default: begin
				ctl_d.state = ST_READ;
			end
		endcase

		// press timing is only as good as the ms grid, hence the spread
		if (mr_valid) begin
			ctl_d.state      = ST_RESET;
			ctl_d.rst_drive  = 1'b1;
			ctl_d.alert      = 1'b0;
			ctl_d.hold_ms    = MS_W'(DEBOUNCE_MS + RST_PULSE_MS);
			ctl_d.phase_ms   = MS_ZERO;
			ctl_d.ack_seen   = 1'b0;
			ctl_d.mr_win_ms  = MS_ZERO;
			ctl_d.mr_high_ms = MS_ZERO;
			tick_restart     = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctl_q             <= '0;
			ctl_q.state       <= ST_READ;
			ctl_q.interval_ms <= MS_W'(STEP_MS);
			ctl_q.rst_drive   <= 1'b1;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	assign sense_en_out        = (ctl_q.state == ST_READ);
	assign alert_out           = ctl_q.alert;
	assign host_reset_n_out    = 1'b0;            // open drain only ever pulls low
	assign host_reset_n_oe_out = ctl_q.rst_drive;
endmodule
